// ==== logic/oh_insert_pkg.sv ====
// Constants shared by the transmit overhead byte insertion block
// Assumes an 8-bit register port and a 50 MHz core clock
package oh_insert_pkg;
    localparam int         CLK_PERIOD_NS       = 20;
    localparam int         PORT_CLK_PERIOD_NS  = 160;
    localparam int         PORT_CLK_DIV        = PORT_CLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int         BITS_PER_BYTE       = 8;
    localparam int         J0_TOH_BYTE_INDEX   = 2;
    localparam int         J0_WAIT_PERIODS     = J0_TOH_BYTE_INDEX * BITS_PER_BYTE;
    localparam int         E1_WAIT_PERIODS     = J0_WAIT_PERIODS + BITS_PER_BYTE;
    localparam int         FRAME_PORT_CLOCKS   = 781;

    localparam logic [15:0] TX_OH_SOURCE_CONTROL_ADDR   = 16'h1902;
    localparam logic [15:0] TX_ORDERWIRE_BYTE_ADDR      = 16'h1943;
    localparam logic [15:0] TX_TRACE_CONTROL_ADDR       = 16'h194F;
    localparam logic [11:0] MAPPER_CONTROL_2_LOW_ADDR   = 12'h601;

    localparam int          ORDERWIRE_SOURCE_SELECT_BIT = 4;
    localparam int          EXT_OH_INSERT_ENABLE_BIT    = 4;
    localparam logic [7:0]  OH_SOURCE_CONTROL_MASK      = 8'h3F;
    localparam logic [7:0]  TRACE_CONTROL_MASK          = 8'h0F;
    localparam logic [1:0]  TRACE_SOURCE_EXTERNAL       = 2'h3;

    localparam logic [7:0]  OH_SOURCE_CONTROL_RESET     = 8'h00;
    localparam logic [7:0]  ORDERWIRE_BYTE_RESET        = 8'h00;
    localparam logic [7:0]  TRACE_CONTROL_RESET         = 8'h00;
    localparam logic [7:0]  MAPPER_CONTROL_2_RESET      = 8'h00;
endpackage : oh_insert_pkg

// ==== logic/oh_serial_byte_capture.sv ====
// Serial byte capture, MSB first, one bit per port clock rising edge
// Assumes the data input is already synchronised and the strobe marks rising edges
`timescale 1ns/1ps
module oh_serial_byte_capture #(
    parameter int PERIOD_W  = 10,
    parameter int FIRST_BIT = 17
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                riseStrobe,
    input  wire logic [PERIOD_W-1:0] periodIdx,
    input  wire logic                accept,
    input  wire logic                dataBit,
    output logic [7:0]               byteOut,
    output logic                     byteDone
);
    import oh_insert_pkg::*;

    localparam logic [PERIOD_W-1:0] FIRST_IDX = PERIOD_W'(FIRST_BIT);
    localparam logic [PERIOD_W-1:0] LAST_IDX  = PERIOD_W'(FIRST_BIT + BITS_PER_BYTE - 1);

    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] byte_ff;
    logic [7:0] nxt_byte;
    logic       done_ff;
    logic       nxt_done;
    logic       inSlot;

    always_comb begin
        inSlot    = (periodIdx >= FIRST_IDX) && (periodIdx <= LAST_IDX);
        nxt_shift = shift_ff;
        nxt_byte  = byte_ff;
        nxt_done  = 1'b0;
        if (riseStrobe && inSlot && accept) begin
            nxt_shift = {shift_ff[6:0], dataBit};
            if (periodIdx == LAST_IDX) begin
                nxt_byte = {shift_ff[6:0], dataBit};
                nxt_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shift_ff <= 8'h00;
            byte_ff  <= 8'h00;
            done_ff  <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            byte_ff  <= nxt_byte;
            done_ff  <= nxt_done;
        end
    end

    assign byteOut  = byte_ff;
    assign byteDone = done_ff;
endmodule : oh_serial_byte_capture

// ==== logic/tx_overhead_byte_insert.sv ====
// Transmit overhead byte insertion: serial overhead port timing, trace and orderwire sourcing
// Assumes an external logic circuit on the serial port and a byte-wide register port on clk
//
// Function
// - Capture each bit on following port rising edge
// - Trace slot starts after two overhead bytes
// - Select set: orderwire register feeds E1 byte
// - Orderwire value register, eight bits, resets zero
// - Mapper bit four enables external overhead port
// - Enabled, select clear: E1 from serial port
// - Trace source 11 takes trace from port
`timescale 1ns/1ps
module tx_overhead_byte_insert #(
    parameter int         FRAME_CLOCKS = oh_insert_pkg::FRAME_PORT_CLOCKS,
    parameter logic [3:0] CHANNEL_N    = 4'h1
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output logic [7:0]       regRdData,
    output logic             oh_port_clock_out,
    output logic             oh_frame_mark_out,
    output logic             oh_slot_enable_out,
    input  wire logic        oh_serial_data_in,
    input  wire logic        oh_insert_request_in,
    input  wire logic        ext_overhead_serial_in,
    output logic             frameStart,
    output logic [7:0]       traceByte,
    output logic             traceByteValid,
    output logic [7:0]       orderwireByte,
    output logic             orderwireByteValid
);
    import oh_insert_pkg::*;

    localparam int PERIOD_W = $clog2(FRAME_CLOCKS + 1);
    localparam int DIV_W    = $clog2(PORT_CLK_DIV);
    localparam logic [DIV_W-1:0]    DIV_LAST   = DIV_W'(PORT_CLK_DIV - 1);
    localparam logic [DIV_W-1:0]    DIV_FALL   = DIV_W'(PORT_CLK_DIV / 2 - 1);
    localparam logic [PERIOD_W-1:0] FRAME_LAST = PERIOD_W'(FRAME_CLOCKS - 1);
    localparam logic [15:0] MAPPER_ADDR = {CHANNEL_N, MAPPER_CONTROL_2_LOW_ADDR};

    // Register file
    logic [7:0] ohSourceCtrl_ff;
    logic [7:0] nxt_ohSourceCtrl;
    logic [7:0] orderwireValue_ff;
    logic [7:0] nxt_orderwireValue;
    logic [7:0] traceCtrl_ff;
    logic [7:0] nxt_traceCtrl;
    logic [7:0] mapperCtrl2_ff;
    logic [7:0] nxt_mapperCtrl2;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;

    always_comb begin
        nxt_ohSourceCtrl   = ohSourceCtrl_ff;
        nxt_orderwireValue = orderwireValue_ff;
        nxt_traceCtrl      = traceCtrl_ff;
        nxt_mapperCtrl2    = mapperCtrl2_ff;
        nxt_rdData         = rdData_ff;
        if (regWrEn) begin
            unique case (regAddr)
                TX_OH_SOURCE_CONTROL_ADDR: nxt_ohSourceCtrl   = regWrData & OH_SOURCE_CONTROL_MASK;
                TX_ORDERWIRE_BYTE_ADDR:    nxt_orderwireValue = regWrData;
                TX_TRACE_CONTROL_ADDR:     nxt_traceCtrl      = regWrData & TRACE_CONTROL_MASK;
                MAPPER_ADDR:               nxt_mapperCtrl2    = regWrData;
                default:                   nxt_rdData         = rdData_ff;
            endcase
        end
        if (regRdEn) begin
            unique case (regAddr)
                TX_OH_SOURCE_CONTROL_ADDR: nxt_rdData = ohSourceCtrl_ff;
                TX_ORDERWIRE_BYTE_ADDR:    nxt_rdData = orderwireValue_ff;
                TX_TRACE_CONTROL_ADDR:     nxt_rdData = traceCtrl_ff;
                MAPPER_ADDR:               nxt_rdData = mapperCtrl2_ff;
                default:                   nxt_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ohSourceCtrl_ff   <= OH_SOURCE_CONTROL_RESET;
            orderwireValue_ff <= ORDERWIRE_BYTE_RESET;
            traceCtrl_ff      <= TRACE_CONTROL_RESET;
            mapperCtrl2_ff    <= MAPPER_CONTROL_2_RESET;
            rdData_ff         <= 8'h00;
        end else begin
            ohSourceCtrl_ff   <= nxt_ohSourceCtrl;
            orderwireValue_ff <= nxt_orderwireValue;
            traceCtrl_ff      <= nxt_traceCtrl;
            mapperCtrl2_ff    <= nxt_mapperCtrl2;
            rdData_ff         <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;

    logic orderwireSoftware;
    logic extInsertEnable;
    logic traceExternal;
    assign orderwireSoftware = ohSourceCtrl_ff[ORDERWIRE_SOURCE_SELECT_BIT];
    assign extInsertEnable   = mapperCtrl2_ff[EXT_OH_INSERT_ENABLE_BIT];
    assign traceExternal     = (traceCtrl_ff[1:0] == TRACE_SOURCE_EXTERNAL);

    // Port clock divider and frame timing
    logic [DIV_W-1:0]    divCnt_ff;
    logic [DIV_W-1:0]    nxt_divCnt;
    logic                portClk_ff;
    logic                nxt_portClk;
    logic [PERIOD_W-1:0] periodCnt_ff;
    logic [PERIOD_W-1:0] nxt_periodCnt;
    logic                mark_ff;
    logic                nxt_mark;
    logic                frameStart_ff;
    logic                nxt_frameStart;
    logic                riseStrobe;

    always_comb begin
        nxt_divCnt     = (divCnt_ff == DIV_LAST) ? '0 : divCnt_ff + DIV_W'(1);
        nxt_portClk    = (divCnt_ff == DIV_LAST) ? 1'b1 : ((divCnt_ff == DIV_FALL) ? 1'b0 : portClk_ff);
        nxt_periodCnt  = periodCnt_ff;
        nxt_mark       = mark_ff;
        nxt_frameStart = 1'b0;
        if (divCnt_ff == DIV_FALL) begin
            nxt_periodCnt = (periodCnt_ff == FRAME_LAST) ? '0 : periodCnt_ff + PERIOD_W'(1);
            nxt_mark      = (periodCnt_ff == FRAME_LAST);
            nxt_frameStart = (periodCnt_ff == FRAME_LAST);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            divCnt_ff     <= '0;
            portClk_ff    <= 1'b0;
            periodCnt_ff  <= FRAME_LAST;
            mark_ff       <= 1'b0;
            frameStart_ff <= 1'b0;
        end else begin
            divCnt_ff     <= nxt_divCnt;
            portClk_ff    <= nxt_portClk;
            periodCnt_ff  <= nxt_periodCnt;
            mark_ff       <= nxt_mark;
            frameStart_ff <= nxt_frameStart;
        end
    end

    assign riseStrobe         = (divCnt_ff == DIV_LAST);
    assign oh_port_clock_out  = portClk_ff;
    assign oh_frame_mark_out  = mark_ff;
    assign oh_slot_enable_out = mark_ff;
    assign frameStart         = frameStart_ff;

    // Pin synchronisers
    logic [2:0] pinMeta_ff;
    logic [2:0] pinSync_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            pinMeta_ff <= 3'h0;
            pinSync_ff <= 3'h0;
        end else begin
            pinMeta_ff <= {oh_insert_request_in, ext_overhead_serial_in, oh_serial_data_in};
            pinSync_ff <= pinMeta_ff;
        end
    end

    // Trace byte slot follows the idle window of two overhead bytes
    logic [7:0] traceCaptured;
    logic       traceDone;
    oh_serial_byte_capture #(
        .PERIOD_W  (PERIOD_W),
        .FIRST_BIT (J0_WAIT_PERIODS + 1)
    ) u_trace_capture (
        .clk        (clk),
        .reset      (reset),
        .riseStrobe (riseStrobe),
        .periodIdx  (periodCnt_ff),
        .accept     (traceExternal | pinSync_ff[2]),
        .dataBit    (pinSync_ff[0]),
        .byteOut    (traceCaptured),
        .byteDone   (traceDone)
    );

    // Orderwire byte slot on the external overhead serial input
    logic [7:0] owCaptured;
    logic       owDone;
    oh_serial_byte_capture #(
        .PERIOD_W  (PERIOD_W),
        .FIRST_BIT (E1_WAIT_PERIODS + 1)
    ) u_orderwire_capture (
        .clk        (clk),
        .reset      (reset),
        .riseStrobe (riseStrobe),
        .periodIdx  (periodCnt_ff),
        .accept     (extInsertEnable & ~orderwireSoftware),
        .dataBit    (pinSync_ff[1]),
        .byteOut    (owCaptured),
        .byteDone   (owDone)
    );

    // Bytes handed to the frame generator
    logic [7:0] trace_ff;
    logic [7:0] nxt_trace;
    logic       traceValid_ff;
    logic       nxt_traceValid;
    logic [7:0] orderwire_ff;
    logic [7:0] nxt_orderwire;
    logic       owValid_ff;
    logic       nxt_owValid;

    always_comb begin
        nxt_trace      = trace_ff;
        nxt_traceValid = 1'b0;
        nxt_orderwire  = orderwire_ff;
        nxt_owValid    = 1'b0;
        if (traceDone) begin
            nxt_trace      = traceCaptured;
            nxt_traceValid = 1'b1;
        end
        if (frameStart_ff && orderwireSoftware) begin
            nxt_orderwire = orderwireValue_ff;
            nxt_owValid   = 1'b1;
        end else if (owDone && extInsertEnable && !orderwireSoftware) begin
            nxt_orderwire = owCaptured;
            nxt_owValid   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trace_ff      <= 8'h00;
            traceValid_ff <= 1'b0;
            orderwire_ff  <= 8'h00;
            owValid_ff    <= 1'b0;
        end else begin
            trace_ff      <= nxt_trace;
            traceValid_ff <= nxt_traceValid;
            orderwire_ff  <= nxt_orderwire;
            owValid_ff    <= nxt_owValid;
        end
    end

    assign traceByte          = trace_ff;
    assign traceByteValid     = traceValid_ff;
    assign orderwireByte      = orderwire_ff;
    assign orderwireByteValid = owValid_ff;
endmodule : tx_overhead_byte_insert

// ==== tb/oh_insert_monitor.sv ====
// Checker for the overhead insertion block, port timing and byte slots
// Assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
module oh_insert_monitor #(
    parameter int FRAME_CLOCKS = 781
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       oh_port_clock_out,
    input  wire logic       oh_frame_mark_out,
    input  wire logic       oh_slot_enable_out,
    input  wire logic       frameStart,
    input  wire logic       traceByteValid,
    input  wire logic       orderwireByteValid
);
    logic [15:0] frameCnt_ff, nxt_frameCnt;
    logic        markPrev_ff, nxt_markPrev, seen_ff, nxt_seen;
    // Clocks since the last rise of the frame mark
    always_comb begin
        nxt_markPrev = reset ? 1'b0 : oh_frame_mark_out;
        nxt_seen = reset ? 1'b0 : seen_ff | (oh_frame_mark_out & ~markPrev_ff);
        nxt_frameCnt = (reset || (oh_frame_mark_out && !markPrev_ff)) ? 16'h0000 : frameCnt_ff + 16'h0001;
    end
    always_ff @(posedge clk) begin
        markPrev_ff <= nxt_markPrev;
        seen_ff     <= nxt_seen;
        frameCnt_ff <= nxt_frameCnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    mark_enable_same_a: assert property (oh_frame_mark_out == oh_slot_enable_out)
        else $error("mark and enable differ");
    clock_high_a: assert property ($rose(oh_port_clock_out) |-> oh_port_clock_out[*4] ##1 !oh_port_clock_out)
        else $error("port clock high phase wrong");
    clock_low_a: assert property ($fell(oh_port_clock_out) && !$past(reset) |-> !oh_port_clock_out[*4] ##1 oh_port_clock_out)
        else $error("port clock low phase wrong");
    mark_width_a: assert property ($rose(oh_frame_mark_out) |-> oh_frame_mark_out[*8] ##1 !oh_frame_mark_out)
        else $error("mark not one port period");
    frame_period_a: assert property ($rose(oh_frame_mark_out) && seen_ff |-> frameCnt_ff == FRAME_CLOCKS * 8 - 1)
        else $error("frame period wrong");
    frame_start_a: assert property ($rose(oh_frame_mark_out) |-> ##[0:2] frameStart)
        else $error("frame start missing");
    trace_slot_a: assert property (traceByteValid |-> frameCnt_ff >= 16'h00BE && frameCnt_ff <= 16'h00CD)
        else $error("trace byte out of slot");
    orderwire_slot_a: assert property (orderwireByteValid |-> frameCnt_ff <= 16'h0004
        || (frameCnt_ff >= 16'h00FE && frameCnt_ff <= 16'h010E)) else $error("orderwire byte out of slot");
    read_hold_a: assert property (!$past(regRdEn) |-> $stable(regRdData))
        else $error("read data changed without read");
    cover property (traceByteValid);
    cover property (orderwireByteValid);
    cover property (frameStart);
endmodule : oh_insert_monitor
bind tx_overhead_byte_insert oh_insert_monitor #(.FRAME_CLOCKS(FRAME_CLOCKS)) monitor (
    .clk(clk), .reset(reset), .regRdEn(regRdEn), .regRdData(regRdData),
    .oh_port_clock_out(oh_port_clock_out), .oh_frame_mark_out(oh_frame_mark_out),
    .oh_slot_enable_out(oh_slot_enable_out), .frameStart(frameStart),
    .traceByteValid(traceByteValid), .orderwireByteValid(orderwireByteValid));

// ==== tb/oh_ext_model.sv ====
// External insertion circuit: trace and orderwire bytes shifted MSB first
// Assumes the port clock, mark and enable come from the block
`timescale 1ns/1ps
module oh_ext_model (
    input  wire logic       portClk,
    input  wire logic       mark,
    input  wire logic       slotEn,
    input  wire logic [7:0] traceVal,
    input  wire logic [7:0] owVal,
    output logic            traceBit,
    output logic            owBit
);
    int slot = 99;
    initial begin
        traceBit = 1'b0;
        owBit = 1'b0;
    end
    always @(posedge portClk) begin
        if (mark && slotEn) begin
            slot <= 0;
        end else if (slot < 99) begin
            slot <= slot + 1;
        end
    end
    // Bits driven on falling edges; outside the slot the line toggles
    always @(negedge portClk) begin
        traceBit <= (slot >= 16 && slot < 24) ? traceVal[23 - slot] : ~traceBit;
        owBit <= (slot >= 24 && slot < 32) ? owVal[31 - slot] : ~owBit;
    end
endmodule : oh_ext_model

// ==== tb/tb.sv ====
// Testbench for the overhead insertion block
// Assumes the block, its package and the external circuit model
`timescale 1ns/1ps
module tb;
    import oh_insert_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, insReq = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWrData = 8'h00, traceVal = 8'h00, owVal = 8'h00, regRdData, traceByte, orderwireByte;
    logic        portClk, mark, slotEn, traceBit, owBit, frameStart, traceByteValid, orderwireByteValid;
    int          num_errors = 0, checked = 0;
    always #10 clk = ~clk;
    tx_overhead_byte_insert #(.FRAME_CLOCKS(40), .CHANNEL_N(4'h2)) dut (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .oh_port_clock_out(portClk), .oh_frame_mark_out(mark), .oh_slot_enable_out(slotEn),
        .oh_serial_data_in(traceBit), .oh_insert_request_in(insReq), .ext_overhead_serial_in(owBit),
        .frameStart(frameStart), .traceByte(traceByte), .traceByteValid(traceByteValid),
        .orderwireByte(orderwireByte), .orderwireByteValid(orderwireByteValid));
    oh_ext_model partner (.portClk(portClk), .mark(mark), .slotEn(slotEn), .traceVal(traceVal),
        .owVal(owVal), .traceBit(traceBit), .owBit(owBit));
    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string name);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        @(negedge clk);
        check(name, regRdData, e);
    endtask : rd
    // Waits for a byte pulse, skipping the first ones after a change
    task automatic grab(input bit ow, input int skip, input logic [7:0] e, input string name);
        int n;
        for (int k = 0; k <= skip; k++) begin
            n = 0;
            @(negedge clk);
            while ((ow ? orderwireByteValid : traceByteValid) !== 1'b1 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            if (n >= 2000) begin
                num_errors++;
                final_report();
            end
        end
        check(name, ow ? orderwireByte : traceByte, e);
    endtask : grab
    // Counts byte pulses over two frames where none may come
    task automatic quiet(input bit ow, input string name);
        int seen = 0;
        repeat (700) begin
            @(negedge clk);
            if ((ow ? orderwireByteValid : traceByteValid) === 1'b1) begin
                seen++;
            end
        end
        check(name, 8'(seen), 8'h00);
    endtask : quiet
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        rd(TX_ORDERWIRE_BYTE_ADDR, 8'h00, "orderwire reset");
        rd(TX_OH_SOURCE_CONTROL_ADDR, 8'h00, "control reset");
        rd(16'h1000, 8'h00, "unmapped read");
        wr(TX_OH_SOURCE_CONTROL_ADDR, 8'hFF);
        rd(TX_OH_SOURCE_CONTROL_ADDR, 8'h3F, "reserved bits");
        wr(TX_ORDERWIRE_BYTE_ADDR, 8'h5A);
        rd(TX_ORDERWIRE_BYTE_ADDR, 8'h5A, "orderwire value");
        grab(1, 1, 8'h5A, "software orderwire");
        wr(TX_ORDERWIRE_BYTE_ADDR, 8'hA5);
        grab(1, 0, 8'hA5, "software orderwire next");
        traceVal = 8'hC3;
        wr(TX_TRACE_CONTROL_ADDR, 8'h03);
        grab(0, 1, 8'hC3, "external trace");
        traceVal = 8'h3C;
        grab(0, 0, 8'h3C, "external trace next");
        traceVal = 8'h81;
        wr(TX_TRACE_CONTROL_ADDR, 8'hF1);
        rd(TX_TRACE_CONTROL_ADDR, 8'h01, "trace control");
        insReq = 1'b1;
        grab(0, 1, 8'h81, "requested trace");
        insReq = 1'b0;
        quiet(0, "trace refused");
        owVal = 8'h96;
        wr({4'h2, MAPPER_CONTROL_2_LOW_ADDR}, 8'h10);
        rd({4'h2, MAPPER_CONTROL_2_LOW_ADDR}, 8'h10, "mapper control");
        wr(TX_OH_SOURCE_CONTROL_ADDR, 8'h00);
        grab(1, 1, 8'h96, "external orderwire");
        wr({4'h2, MAPPER_CONTROL_2_LOW_ADDR}, 8'h00);
        quiet(1, "orderwire refused");
        final_report();
    end
endmodule : tb
